// file: core/uasc_core.v
`timescale 1ns/1ns
`include "uasc_map.vh"

module uasc_core #(
    parameter [15:0] POR_CYC = `UASC_POR_CYC,
    parameter [17:0] SUSP_CYC = `UASC_SUSP_CYC,
    parameter [20:0] HID_CYC = `UASC_HID_CYC
)(
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire vbus_det_i,
    input wire bus_idle_i,
    input wire sof_i,
    input wire tok_valid_i,
    input wire [3:0] tok_ep_i,
    input wire ctrl_req_i,
    input wire [1:0] ctrl_code_i,
    input wire [1:0] ctrl_iface_i,
    input wire [3:0] ctrl_alt_i,
    input wire out_valid_i,
    input wire [7:0] out_data_i,
    input wire out_pkt_end_i,
    input wire [1:0] play_rate_i,
    input wire dac_tick_i,
    input wire adc_valid_i,
    input wire [15:0] adc_l_i,
    input wire [15:0] adc_r_i,
    input wire dig_det_i,
    input wire dig_lock_i,
    input wire [1:0] dig_rate_i,
    input wire [1:0] dig_cm_i,
    input wire dig_valid_i,
    input wire [15:0] dig_l_i,
    input wire [15:0] dig_r_i,
    input wire key_mute_in_i,
    input wire key_vol_up_in_i,
    input wire key_vol_down_in_i,
    output wire setup_ready_o,
    output reg configured_o,
    output wire ep_ok_o,
    output reg ctrl_ack_o,
    output reg ctrl_stall_o,
    output reg [2:0] play_alt_o,
    output reg [3:0] rec_alt_o,
    output wire play_active_o,
    output reg play_valid_o,
    output reg [15:0] play_l_o,
    output reg [15:0] play_r_o,
    output wire dig_out_en_o,
    output wire [1:0] dig_out_cm_o,
    output wire rec_src_dig_o,
    output reg rec_valid_o,
    output reg [15:0] rec_l_o,
    output reg [15:0] rec_r_o,
    output wire rec_bits16_o,
    output wire rec_stereo_o,
    output wire hid_valid_o,
    output wire [2:0] hid_keys_o,
    output wire [15:0] hid_usage_o,
    output reg suspend_flag_n_o
);

reg vbus_meta;
reg vbus_sync;
reg idle_meta;
reg idle_sync;
reg [15:0] por_cnt;
reg por_done;
reg [17:0] idle_cnt;
reg [1:0] pstate;
reg draining;
reg [1:0] byte_cnt;
reg [7:0] lo_byte;
reg [15:0] left_hold;
reg [31:0] buf_mem [0:(1 << `UASC_BUF_AW) - 1];
reg [`UASC_BUF_AW:0] wr_ptr;
reg [`UASC_BUF_AW:0] rd_ptr;
reg alt_ok;
reg [2:0] rec_rate;
reg [15:0] next_rec_l;
reg [15:0] next_rec_r;

// VBUS detect and bus idle pins pass two flops before anything looks at them
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        vbus_meta <= 1'b0;
        vbus_sync <= 1'b0;
        idle_meta <= 1'b1;
        idle_sync <= 1'b1;
    end
    else
    begin
        vbus_meta <= vbus_det_i;
        vbus_sync <= vbus_meta;
        idle_meta <= bus_idle_i;
        idle_sync <= idle_meta;
    end
end

// Power-on release timer; a supply drop restarts it and acts as detach
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        por_cnt <= 16'h0000;
        por_done <= 1'b0;
    end
    else if (!vbus_sync)
    begin
        por_cnt <= 16'h0000;
        por_done <= 1'b0;
    end
    else if (!por_done)
    begin
        if (por_cnt == POR_CYC - 16'h0001)
            por_done <= 1'b1;
        else
            por_cnt <= por_cnt + 16'h0001;
    end
end

assign setup_ready_o = por_done;

// Suspend after continuous idle; the clock keeps running regardless
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        idle_cnt <= 18'h0_0000;
        suspend_flag_n_o <= 1'b1;
    end
    else if (!idle_sync || !por_done)
    begin
        idle_cnt <= 18'h0_0000;
        suspend_flag_n_o <= 1'b1;
    end
    else if (idle_cnt == SUSP_CYC - 18'h0_0001)
        suspend_flag_n_o <= 1'b0;
    else
        idle_cnt <= idle_cnt + 18'h0_0001;
end

// Only the four implemented endpoints answer tokens
assign ep_ok_o = tok_valid_i && (tok_ep_i == `UASC_EP_CTRL ||
    tok_ep_i == `UASC_EP_ISO_OUT || tok_ep_i == `UASC_EP_ISO_IN ||
    tok_ep_i == `UASC_EP_HID);

// Alternate setting range per interface
always @*
begin
    case (ctrl_iface_i)
        `UASC_IF_PLAY: alt_ok = ctrl_alt_i <= `UASC_PLAY_ALT_MAX;
        `UASC_IF_REC: alt_ok = ctrl_alt_i <= `UASC_REC_ALT_MAX;
        default: alt_ok = ctrl_alt_i == 4'h0;
    endcase
end

// Control endpoint request handling
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        configured_o <= 1'b0;
        play_alt_o <= 3'h0;
        rec_alt_o <= 4'h0;
        ctrl_ack_o <= 1'b0;
        ctrl_stall_o <= 1'b0;
    end
    else if (!por_done)
    begin
        configured_o <= 1'b0;
        play_alt_o <= 3'h0;
        rec_alt_o <= 4'h0;
        ctrl_ack_o <= 1'b0;
        ctrl_stall_o <= ctrl_req_i;
    end
    else
    begin
        ctrl_ack_o <= 1'b0;
        ctrl_stall_o <= 1'b0;
        if (ctrl_req_i)
        begin
            case (ctrl_code_i)
                `UASC_REQ_SET_CFG:
                begin
                    configured_o <= ctrl_alt_i != 4'h0;
                    play_alt_o <= 3'h0;
                    rec_alt_o <= 4'h0;
                    ctrl_ack_o <= 1'b1;
                end
                `UASC_REQ_SET_IF:
                begin
                    if (configured_o && alt_ok)
                    begin
                        if (ctrl_iface_i == `UASC_IF_PLAY)
                            play_alt_o <= ctrl_alt_i[2:0];
                        if (ctrl_iface_i == `UASC_IF_REC)
                            rec_alt_o <= ctrl_alt_i;
                        ctrl_ack_o <= 1'b1;
                    end
                    else
                        ctrl_stall_o <= 1'b1;
                end
                default: ctrl_ack_o <= 1'b1;
            endcase
        end
    end
end

// Playback format decode, alternates 1 to 6 in order
wire p_bits16 = play_alt_o == 3'h1 || play_alt_o == 3'h2;
wire p_stereo = play_alt_o[0];
wire p_offbin = play_alt_o == 3'h5 || play_alt_o == 3'h6;
wire [7:0] in_byte = p_offbin ? out_data_i ^ `UASC_OFFSET_BIAS : out_data_i;
wire [15:0] samp = p_bits16 ? {in_byte, lo_byte} : {in_byte, 8'h00};
wire samp_done = p_bits16 ? byte_cnt[0] : 1'b1;
wire chan = p_bits16 ? byte_cnt[1] : byte_cnt[0];
wire frame_done = samp_done && (!p_stereo || chan);
wire [31:0] frame = p_stereo ? {left_hold, samp} : {samp, samp};

// Buffer state; overflow drops data since the host paces the stream
wire buf_empty = wr_ptr == rd_ptr;
wire buf_full = wr_ptr[`UASC_BUF_AW] != rd_ptr[`UASC_BUF_AW] &&
    wr_ptr[`UASC_BUF_AW-1:0] == rd_ptr[`UASC_BUF_AW-1:0];
wire stream_on = configured_o && play_alt_o != 3'h0 && !draining;
wire take_byte = out_valid_i && stream_on && pstate != `UASC_P_ARMED;
wire push = take_byte && frame_done && !buf_full;
wire pop = dac_tick_i && pstate == `UASC_P_PLAY && !buf_empty;

// Byte assembly into frames
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        byte_cnt <= 2'h0;
        lo_byte <= 8'h00;
        left_hold <= `UASC_MIDSCALE_ZERO;
    end
    else if (!stream_on || out_pkt_end_i)
        byte_cnt <= 2'h0; // Packets always hold whole frames
    else if (take_byte)
    begin
        byte_cnt <= frame_done ? 2'h0 : byte_cnt + 2'h1;
        if (!samp_done)
            lo_byte <= in_byte;
        else if (!chan)
            left_hold <= samp;
    end
end

// Frame store
always @(posedge ref_clk_i)
begin
    if (push)
        buf_mem[wr_ptr[`UASC_BUF_AW-1:0]] <= frame;
end

// Playback sequencing: fill first packet, arm, start on next frame mark
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        pstate <= `UASC_P_IDLE;
        draining <= 1'b0;
        wr_ptr <= {(`UASC_BUF_AW + 1){1'b0}};
        rd_ptr <= {(`UASC_BUF_AW + 1){1'b0}};
    end
    else
    begin
        if (push)
            wr_ptr <= wr_ptr + 1'b1;
        if (pop)
            rd_ptr <= rd_ptr + 1'b1;
        case (pstate)
            `UASC_P_IDLE:
            begin
                draining <= 1'b0;
                wr_ptr <= {(`UASC_BUF_AW + 1){1'b0}};
                rd_ptr <= {(`UASC_BUF_AW + 1){1'b0}};
                if (take_byte)
                begin
                    pstate <= `UASC_P_FILL;
                    if (push)
                        wr_ptr <= {{`UASC_BUF_AW{1'b0}}, 1'b1};
                end
            end
            `UASC_P_FILL:
                if (!stream_on)
                    pstate <= `UASC_P_IDLE;
                else if (out_pkt_end_i)
                    pstate <= `UASC_P_ARMED;
            `UASC_P_ARMED:
                if (!stream_on)
                    pstate <= `UASC_P_IDLE;
                else if (sof_i)
                    pstate <= `UASC_P_PLAY;
            `UASC_P_PLAY:
            begin
                // Stopping lets the queued samples finish first
                if (!configured_o || play_alt_o == 3'h0)
                    draining <= 1'b1;
                if ((draining || !configured_o || play_alt_o == 3'h0) &&
                    (buf_empty || (pop && rd_ptr + 1'b1 == wr_ptr)))
                    pstate <= `UASC_P_IDLE;
            end
            default: pstate <= `UASC_P_IDLE;
        endcase
    end
end

assign play_active_o = pstate == `UASC_P_PLAY;

// One sample pair drives both the DAC path and the digital output
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        play_valid_o <= 1'b0;
        play_l_o <= `UASC_MIDSCALE_ZERO;
        play_r_o <= `UASC_MIDSCALE_ZERO;
    end
    else
    begin
        play_valid_o <= dac_tick_i;
        if (pop)
        begin
            play_l_o <= buf_mem[rd_ptr[`UASC_BUF_AW-1:0]][31:16];
            play_r_o <= buf_mem[rd_ptr[`UASC_BUF_AW-1:0]][15:0];
        end
        else if (dac_tick_i)
        begin
            play_l_o <= `UASC_MIDSCALE_ZERO;
            play_r_o <= `UASC_MIDSCALE_ZERO;
        end
    end
end

// Playback rate codes 0 to 2 are link rates; code 3 is not one
assign dig_out_en_o = play_active_o && play_rate_i != 2'h3;
assign dig_out_cm_o = `UASC_CM_ORIGINAL;

// Record format decode
assign rec_bits16_o = rec_alt_o <= `UASC_REC_ALT_16_MAX;
assign rec_stereo_o = rec_alt_o[0];
always @*
begin
    if (rec_bits16_o)
        rec_rate = rec_alt_o[3:1] - {2'h0, ~rec_alt_o[0]};
    else if (rec_alt_o <= `UASC_REC_ALT_16K_MAX)
        rec_rate = `UASC_RATE_16;
    else
        rec_rate = `UASC_RATE_8;
end

// Digital input used only when locked, original and at the stream's rate
wire rec_on = configured_o && rec_alt_o != 4'h0;
assign rec_src_dig_o = dig_det_i && dig_lock_i &&
    dig_cm_i == `UASC_CM_ORIGINAL &&
    rec_rate <= `UASC_RATE_32 && rec_rate[1:0] == dig_rate_i;
wire src_valid = rec_src_dig_o ? dig_valid_i : adc_valid_i;
wire [15:0] src_l = rec_src_dig_o ? dig_l_i : adc_l_i;
wire [15:0] src_r = rec_src_dig_o ? dig_r_i : adc_r_i;
wire [16:0] mix = {src_l[15], src_l} + {src_r[15], src_r};

// Down-mix and truncation for the selected capture format
always @*
begin
    next_rec_l = rec_stereo_o ? src_l : mix[16:1];
    next_rec_r = rec_stereo_o ? src_r : mix[16:1];
    if (!rec_bits16_o)
    begin
        next_rec_l = {8'h00, next_rec_l[15:8]};
        next_rec_r = {8'h00, next_rec_r[15:8]};
    end
end

// Capture pulse; idle record path holds midscale zero
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        rec_valid_o <= 1'b0;
        rec_l_o <= `UASC_MIDSCALE_ZERO;
        rec_r_o <= `UASC_MIDSCALE_ZERO;
    end
    else
    begin
        rec_valid_o <= rec_on && src_valid;
        if (!rec_on)
        begin
            rec_l_o <= `UASC_MIDSCALE_ZERO;
            rec_r_o <= `UASC_MIDSCALE_ZERO;
        end
        else if (src_valid)
        begin
            rec_l_o <= next_rec_l;
            rec_r_o <= next_rec_r;
        end
    end
end

// Key reports run apart from both audio streams
uasc_hid_report #(
    .HID_CYC(HID_CYC)
) u_hid (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(configured_o),
    .key_mute_in_i(key_mute_in_i),
    .key_vol_up_in_i(key_vol_up_in_i),
    .key_vol_down_in_i(key_vol_down_in_i),
    .hid_valid_o(hid_valid_o),
    .hid_keys_o(hid_keys_o),
    .hid_usage_o(hid_usage_o)
);

endmodule // uasc_core

// file: core/uasc_hid_report.v
`timescale 1ns/1ns
`include "uasc_map.vh"

module uasc_hid_report #(
    parameter [20:0] HID_CYC = `UASC_HID_CYC
)(
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire enable_i,
    input wire key_mute_in_i,
    input wire key_vol_up_in_i,
    input wire key_vol_down_in_i,
    output reg hid_valid_o,
    output reg [2:0] hid_keys_o,
    output reg [15:0] hid_usage_o
);

reg [2:0] key_meta;
reg [2:0] key_sync;
reg [20:0] period;
reg [15:0] next_usage;

// Key pins are asynchronous; two stages before use
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        key_meta <= 3'h0;
        key_sync <= 3'h0;
    end
    else
    begin
        key_meta <= {key_vol_down_in_i, key_vol_up_in_i, key_mute_in_i};
        key_sync <= key_meta;
    end
end

// Usage of the first pressed key, mute taking priority
always @*
begin
    next_usage = 16'h0000;
    if (key_sync[0])
        next_usage = `UASC_USE_MUTE;
    else if (key_sync[1])
        next_usage = `UASC_USE_VOL_UP;
    else if (key_sync[2])
        next_usage = `UASC_USE_VOL_DOWN;
end

// Report timer; keys only go to the host, never into audio data
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        period <= 21'h00_0000;
        hid_valid_o <= 1'b0;
        hid_keys_o <= 3'h0;
        hid_usage_o <= 16'h0000;
    end
    else
    begin
        hid_valid_o <= 1'b0;
        if (!enable_i)
            period <= 21'h00_0000;
        else if (period == HID_CYC - 21'h00_0001)
        begin
            period <= 21'h00_0000;
            hid_valid_o <= 1'b1;
            hid_keys_o <= key_sync;
            hid_usage_o <= next_usage;
        end
        else
            period <= period + 21'h00_0001;
    end
end

endmodule // uasc_hid_report

// file: core/uasc_map.vh
`ifndef UASC_MAP_VH
`define UASC_MAP_VH

// Clock rate and timing targets
`define UASC_CLK_HZ 50000000
`define UASC_POR_US 700
`define UASC_HID_MS 32
`define UASC_SUSP_MS 5
// Sized cycle counts at 50 MHz: 700 us, 32 ms and 5 ms
`define UASC_POR_CYC 16'h88B8
`define UASC_HID_CYC 21'h18_6A00
`define UASC_SUSP_CYC 18'h3_D090

// Endpoint numbers
`define UASC_EP_CTRL 4'h0
`define UASC_EP_ISO_OUT 4'h2
`define UASC_EP_ISO_IN 4'h4
`define UASC_EP_HID 4'h5

// Control request codes from the protocol engine
`define UASC_REQ_STD 2'h0
`define UASC_REQ_SET_CFG 2'h1
`define UASC_REQ_SET_IF 2'h2
`define UASC_REQ_CLASS 2'h3

// Interface numbers and highest alternate settings
`define UASC_IF_PLAY 2'h1
`define UASC_IF_REC 2'h2
`define UASC_PLAY_ALT_MAX 4'h6
`define UASC_REC_ALT_MAX 4'hE
`define UASC_REC_ALT_16_MAX 4'hA
`define UASC_REC_ALT_16K_MAX 4'hC

// Rate codes: 48, 44.1, 32, 22.05, 16, 8 kHz
`define UASC_RATE_48 3'h0
`define UASC_RATE_32 3'h2
`define UASC_RATE_16 3'h4
`define UASC_RATE_8 3'h5

// Sample values
`define UASC_MIDSCALE_ZERO 16'h0000
`define UASC_OFFSET_BIAS 8'h80
`define UASC_CM_ORIGINAL 2'h0

// HID usage codes
`define UASC_USE_MUTE 16'hE209
`define UASC_USE_VOL_UP 16'hE909
`define UASC_USE_VOL_DOWN 16'hEA09

// Playback buffer: one 1 ms packet at 48 kHz is 48 frames
`define UASC_BUF_AW 6

// Playback states
`define UASC_P_IDLE 2'h0
`define UASC_P_FILL 2'h1
`define UASC_P_ARMED 2'h2
`define UASC_P_PLAY 2'h3

`endif

// file: tb/uasc_core_bench.sv
`timescale 1ns/1ns
module uasc_core_bench;
    // Short counts keep the run brief
    localparam logic [15:0] POR = 16'h0014;
    localparam logic [17:0] SUSP = 18'h0032;
    localparam logic [20:0] HID = 21'h0064;
    logic ref_clk_i, rst_n_i, vbus_det_i, bus_idle_i, dac_tick_i, adc_valid_i, dig_valid_i;
    logic dig_det_i, dig_lock_i, key_mute_in_i, key_vol_up_in_i, key_vol_down_in_i;
    logic [1:0] play_rate_i, dig_rate_i, dig_cm_i;
    logic [15:0] adc_l_i, adc_r_i, dig_l_i, dig_r_i, l, r;
    wire sof_i, tok_valid_i, ctrl_req_i, out_valid_i, out_pkt_end_i, setup_ready_o;
    wire configured_o, ep_ok_o, ctrl_ack_o, ctrl_stall_o, play_active_o, play_valid_o;
    wire dig_out_en_o, rec_src_dig_o, rec_valid_o, rec_bits16_o, rec_stereo_o, hid_valid_o;
    wire suspend_flag_n_o;
    wire [3:0] tok_ep_i, ctrl_alt_i, rec_alt_o;
    wire [1:0] ctrl_code_i, ctrl_iface_i, dig_out_cm_o;
    wire [7:0] out_data_i;
    wire [2:0] play_alt_o, hid_keys_o;
    wire [15:0] play_l_o, play_r_o, rec_l_o, rec_r_o, hid_usage_o;
    int error_cnt;
    int comparisons;
    int n;
    logic ack, stall, ok;

    uasc_core #(.POR_CYC(POR), .SUSP_CYC(SUSP), .HID_CYC(HID)) dut_u (.*);

    uasc_host_model host_u (.ref_clk_i, .ctrl_ack_i(ctrl_ack_o), .ctrl_stall_i(ctrl_stall_o),
        .ep_ok_i(ep_ok_o), .ctrl_req_o(ctrl_req_i), .ctrl_code_o(ctrl_code_i),
        .ctrl_iface_o(ctrl_iface_i), .ctrl_alt_o(ctrl_alt_i), .tok_valid_o(tok_valid_i),
        .tok_ep_o(tok_ep_i), .out_valid_o(out_valid_i), .out_data_o(out_data_i),
        .out_pkt_end_o(out_pkt_end_i), .sof_o(sof_i));

    // 50 MHz clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic good, input string what);
        comparisons++;
        if (good !== 1'b1)
        begin
            error_cnt++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A wait that ran out ends the run
    task automatic give_up(input int lim, input string what);
        chk(n < lim, what);
        if (n >= lim)
            tally_and_finish();
    endtask

    // Sample request; answer read in the cycle after
    task automatic tick();
        @(negedge ref_clk_i);
        dac_tick_i = 1'b1;
        @(negedge ref_clk_i);
        dac_tick_i = 1'b0;
        chk(play_valid_o === 1'b1, "no tick answer");
        l = play_l_o;
        r = play_r_o;
    endtask

    // Same sample on both sources, channels swapped on the digital one
    task automatic rec_put(input logic [15:0] a, input logic [15:0] b);
        @(negedge ref_clk_i);
        {adc_valid_i, dig_valid_i} = 2'b11;
        {adc_l_i, adc_r_i, dig_l_i, dig_r_i} = {a, b, b, a};
        @(negedge ref_clk_i);
        {adc_valid_i, dig_valid_i} = 2'b00;
        chk(rec_valid_o === 1'b1, "no record answer");
    endtask

    initial
    begin
        {rst_n_i, vbus_det_i, bus_idle_i, dac_tick_i, adc_valid_i, dig_valid_i} = '0;
        {dig_det_i, dig_lock_i, key_mute_in_i, key_vol_up_in_i, key_vol_down_in_i} = '0;
        {play_rate_i, dig_rate_i, dig_cm_i, adc_l_i, adc_r_i, dig_l_i, dig_r_i} = '0;
        repeat (8) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        host_u.ctrl(2'h1, 2'h0, 4'h1, ack, stall);
        chk(stall === 1'b1 && ack === 1'b0, "early request taken");
        vbus_det_i = 1'b1;
        for (n = 0; setup_ready_o !== 1'b1 && n < 100; n++) @(negedge ref_clk_i);
        give_up(100, "never ready");
        chk(n >= POR && n <= POR + 4, "reset release time");
        host_u.ctrl(2'h2, 2'h1, 4'h1, ack, stall);
        chk(stall === 1'b1, "early iface");
        host_u.ctrl(2'h1, 2'h0, 4'h1, ack, stall);
        chk(ack === 1'b1 && configured_o === 1'b1, "config refused");
        host_u.ctrl(2'h3, 2'h0, 4'h0, ack, stall);
        chk(ack === 1'b1, "class request refused");
        for (int e = 0; e < 16; e++)
        begin
            host_u.token(e[3:0], ok);
            chk(ok === (e == 0 || e == 2 || e == 4 || e == 5), "endpoint decode");
        end
        for (int a = 1; a < 8; a++)
        begin
            host_u.ctrl(2'h2, 2'h1, a[3:0], ack, stall);
            chk(a < 7 ? ack === 1'b1 && play_alt_o === a[2:0] : stall === 1'b1, "play alt");
        end
        for (int a = 0; a < 16; a++)
        begin
            host_u.ctrl(2'h2, 2'h2, a[3:0], ack, stall);
            chk(a < 15 ? ack === 1'b1 && rec_alt_o === a[3:0] : stall === 1'b1, "rec alt");
            if (a > 0 && a < 15)
                chk(rec_bits16_o === (a <= 10) && rec_stereo_o === (a % 2 == 1), "format");
        end
        // Playback: idle, buffered, started on the frame mark, stopped, then restarted in offset mono
        host_u.ctrl(2'h2, 2'h1, 4'h1, ack, stall);
        tick();
        chk(l === 16'h0000 && r === 16'h0000, "idle not midscale");
        host_u.packet('{8'h00, 8'hA5, 8'h00, 8'h5A, 8'h01, 8'hA5, 8'h01, 8'h5A});
        tick();
        chk(l === 16'h0000 && play_active_o === 1'b0, "early play");
        host_u.frame_mark();
        chk(play_active_o === 1'b1, "no start on frame");
        tick();
        chk(l === 16'hA500 && r === 16'h5A00, "first frame");
        tick();
        chk(l === 16'hA501 && r === 16'h5A01, "second frame");
        host_u.ctrl(2'h2, 2'h1, 4'h0, ack, stall);
        for (n = 0; play_active_o !== 1'b0 && n < 20; n++) @(negedge ref_clk_i);
        give_up(20, "no stop");
        host_u.ctrl(2'h2, 2'h1, 4'h6, ack, stall);
        host_u.packet('{8'h90});
        host_u.frame_mark();
        tick();
        chk(l === 16'h1000 && r === 16'h1000, "offset mono");
        chk(dig_out_en_o === 1'b1, "link output off");
        // Record from converter, then digital input, then a copied stream
        host_u.ctrl(2'h2, 2'h2, 4'h1, ack, stall);
        rec_put(16'h1357, 16'h2468);
        chk(rec_l_o === 16'h1357 && rec_r_o === 16'h2468, "converter record");
        {dig_det_i, dig_lock_i} = 2'b11;
        rec_put(16'h1357, 16'h2468);
        chk(rec_src_dig_o === 1'b1 && rec_l_o === 16'h2468, "digital record");
        host_u.ctrl(2'h2, 2'h2, 4'h2, ack, stall);
        rec_put(16'h0100, 16'h0300);
        chk(rec_l_o === 16'h0200, "mono down-mix");
        dig_cm_i = 2'h1;
        @(negedge ref_clk_i);
        chk(rec_src_dig_o === 1'b0, "copy not refused");
        // Key reports and their spacing
        key_mute_in_i = 1'b1;
        for (n = 0; (hid_valid_o !== 1'b1 || n < 3) && n < 300; n++) @(negedge ref_clk_i);
        give_up(300, "no key report");
        chk(hid_keys_o === 3'h1 && hid_usage_o === 16'hE209, "mute report");
        {key_mute_in_i, key_vol_up_in_i} = 2'b01;
        n = 0;
        do
        begin
            @(negedge ref_clk_i);
            n++;
        end
        while (hid_valid_o !== 1'b1 && n < 300);
        chk(n == HID && hid_usage_o === 16'hE909, "report period");
        // Suspend after steady idle, prompt wake
        bus_idle_i = 1'b1;
        for (n = 0; suspend_flag_n_o !== 1'b0 && n < 200; n++) @(negedge ref_clk_i);
        give_up(200, "no suspend");
        chk(n >= SUSP && n <= SUSP + 4, "suspend delay");
        bus_idle_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        chk(suspend_flag_n_o === 1'b1, "no wake");
        tally_and_finish();
    end
endmodule // uasc_core_bench

// file: tb/uasc_core_properties.sv
`timescale 1ns/1ns
module uasc_core_properties (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire ctrl_req_i,
    input wire [1:0] ctrl_code_i,
    input wire [1:0] ctrl_iface_i,
    input wire [3:0] ctrl_alt_i,
    input wire ctrl_ack_o,
    input wire ctrl_stall_o,
    input wire setup_ready_o,
    input wire tok_valid_i,
    input wire [3:0] tok_ep_i,
    input wire ep_ok_o,
    input wire [1:0] dig_out_cm_o,
    input wire dac_tick_i,
    input wire sof_i,
    input wire play_active_o,
    input wire play_valid_o,
    input wire [15:0] play_l_o,
    input wire [15:0] play_r_o,
    input wire rec_src_dig_o,
    input wire dig_det_i,
    input wire dig_lock_i,
    input wire [1:0] dig_cm_i,
    input wire bus_idle_i,
    input wire suspend_flag_n_o,
    input wire hid_valid_o,
    input wire [2:0] hid_keys_o,
    input wire [15:0] hid_usage_o
);
    // Single clock domain
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Control answers: exactly one of ack or stall, one cycle on
    property p_answer; ctrl_req_i |=> ctrl_ack_o != ctrl_stall_o; endproperty
    a_answer: assert property (p_answer) else $error("bad answer");
    property p_early; ctrl_req_i && !setup_ready_o |=> ctrl_stall_o; endproperty
    a_early: assert property (p_early) else $error("early accept");
    property p_alt_bad; ctrl_req_i && ctrl_code_i == 2'h2 && ((ctrl_iface_i == 2'h1 &&
        ctrl_alt_i > 4'h6) || (ctrl_iface_i == 2'h2 && ctrl_alt_i == 4'hF)) |=> ctrl_stall_o;
    endproperty
    a_alt_bad: assert property (p_alt_bad) else $error("bad alt taken");
    // Endpoint and copy marking relations hold every cycle
    property p_ep; ep_ok_o == (tok_valid_i && tok_ep_i inside {0, 2, 4, 5}); endproperty
    a_ep: assert property (p_ep) else $error("ep decode");
    property p_cm; dig_out_cm_o == 2'h0; endproperty
    a_cm: assert property (p_cm) else $error("not original");
    // Playback idles at midscale and starts only on a frame mark; record source, wake and key usage
    property p_idle; dac_tick_i && !play_active_o |=> play_valid_o && play_l_o == 16'h0000
        && play_r_o == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("idle not zero");
    property p_sof; $rose(play_active_o) |-> $past(sof_i); endproperty
    a_sof: assert property (p_sof) else $error("start off frame");
    property p_src; rec_src_dig_o |-> dig_det_i && dig_lock_i && dig_cm_i == 2'h0; endproperty
    a_src: assert property (p_src) else $error("bad source");
    property p_wake; $fell(bus_idle_i) |-> ##[1:4] suspend_flag_n_o; endproperty
    a_wake: assert property (p_wake) else $error("slow wake");
    property p_usage; hid_valid_o |-> hid_usage_o == (hid_keys_o[0] ? 16'hE209 :
        hid_keys_o[1] ? 16'hE909 : hid_keys_o[2] ? 16'hEA09 : 16'h0000); endproperty
    a_usage: assert property (p_usage) else $error("bad usage");

    // Main scenarios reached
    c_play: cover property ($rose(play_active_o));
    c_susp: cover property ($fell(suspend_flag_n_o));
    c_hid: cover property (hid_valid_o);
    c_early: cover property (ctrl_req_i && !setup_ready_o);
endmodule // uasc_core_properties

bind uasc_core uasc_core_properties props_u (.*);

// file: tb/uasc_host_model.sv
`timescale 1ns/1ns
module uasc_host_model (
    input wire ref_clk_i,
    input wire ctrl_ack_i,
    input wire ctrl_stall_i,
    input wire ep_ok_i,
    output logic ctrl_req_o,
    output logic [1:0] ctrl_code_o,
    output logic [1:0] ctrl_iface_o,
    output logic [3:0] ctrl_alt_o,
    output logic tok_valid_o,
    output logic [3:0] tok_ep_o,
    output logic out_valid_o,
    output logic [7:0] out_data_o,
    output logic out_pkt_end_o,
    output logic sof_o
);
    // Quiet bus at start
    initial
    begin
        {ctrl_req_o, ctrl_code_o, ctrl_iface_o, ctrl_alt_o, tok_valid_o} = '0;
        {tok_ep_o, out_valid_o, out_data_o, out_pkt_end_o, sof_o} = '0;
    end

    // Control via endpoint zero; fields garbled after release
    task automatic ctrl(input logic [1:0] code, input logic [1:0] ifc, input logic [3:0] alt,
                        output logic ack, output logic stall);
        @(negedge ref_clk_i);
        {ctrl_code_o, ctrl_iface_o, ctrl_alt_o} = {code, ifc, alt};
        ctrl_req_o = 1'b1;
        @(negedge ref_clk_i);
        ctrl_req_o = 1'b0;
        {ctrl_code_o, ctrl_iface_o, ctrl_alt_o} = ~{code, ifc, alt};
        ack = ctrl_ack_i;
        stall = ctrl_stall_i;
    endtask

    // Token pulse; endpoint match read while it is up
    task automatic token(input logic [3:0] ep, output logic ok);
        @(negedge ref_clk_i);
        tok_valid_o = 1'b1;
        tok_ep_o = ep;
        #2;
        ok = ep_ok_i;
        @(negedge ref_clk_i);
        tok_valid_o = 1'b0;
        tok_ep_o = ~ep;
    endtask

    // Back-to-back bytes, then the packet end mark
    task automatic packet(input logic [7:0] b[$]);
        foreach (b[i])
        begin
            @(negedge ref_clk_i);
            out_valid_o = 1'b1;
            out_data_o = b[i];
        end
        @(negedge ref_clk_i);
        out_valid_o = 1'b0;
        out_data_o = ~out_data_o;
        out_pkt_end_o = 1'b1;
        @(negedge ref_clk_i);
        out_pkt_end_o = 1'b0;
    endtask

    // Start-of-frame pulse
    task automatic frame_mark();
        @(negedge ref_clk_i);
        sof_o = 1'b1;
        @(negedge ref_clk_i);
        sof_o = 1'b0;
    endtask
endmodule // uasc_host_model
